// *** inc/tcc_consts.svh ***
// Purpose: Constants of the three-channel capture timer
// Assumes: Included by bare name from package and design
// Notes:   Definitions only
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register addresses
`define TCC_ADDR_MODE      16'hff65
`define TCC_ADDR_PRESCALE  16'hff66
`define TCC_ADDR_CAPDIV    16'hff67
`define TCC_ADDR_COUNT     16'hff10
`define TCC_ADDR_CAP0      16'hff12
`define TCC_ADDR_CAP1      16'hff14
`define TCC_ADDR_CAP2      16'hff16

// Reset values
`define TCC_RST_MODE       8'h00
`define TCC_RST_PRESCALE   8'h00
`define TCC_RST_CAPDIV     8'h00
`define TCC_RST_COUNT      16'h0000

// Field positions
`define TCC_BIT_POE        0
`define TCC_BIT_RUN        2
`define TCC_FLD_CLK_LO     0
`define TCC_FLD_EDGE_LO    2
`define TCC_FLD_CAPDIV_LO  0

// Masks of the writable bits
`define TCC_MASK_MODE      8'h05
`define TCC_MASK_CAPDIV    8'h03

// Prescaler terminal masks: divide by 4, 8, 32, 128
`define TCC_PRE_W          7
`define TCC_DIV4_MASK      7'h03
`define TCC_DIV8_MASK      7'h07
`define TCC_DIV32_MASK     7'h1f
`define TCC_DIV128_MASK    7'h7f

// Channel 2 capture divider masks: 1, 2, 4, 8
`define TCC_CDIV1_MASK     3'h0
`define TCC_CDIV2_MASK     3'h1
`define TCC_CDIV4_MASK     3'h3
`define TCC_CDIV8_MASK     3'h7

`endif

// *** inc/tcc_pkg.sv ***
// Purpose: Types of the three-channel capture timer
// Assumes: Nothing beyond the constants header
// Notes:   Nothing is imported by users
`include "tcc_consts.svh"
package tcc_pkg;

   // CPU side register request, all fields sampled on one clock edge
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } tcc_cpu_req_t;

   typedef enum logic [1:0] {
      TCC_EDGE_FALL = 2'h0,
      TCC_EDGE_RISE = 2'h1,
      TCC_EDGE_BAD  = 2'h2,
      TCC_EDGE_BOTH = 2'h3
   } tcc_edge_t;

endpackage

// *** rtl/tcc_capture_timer.sv ***
// Purpose: 16-bit free-running counter with three input-capture channels
// Assumes: ref_clk_i 100 MHz is the main clock; capture pins are asynchronous
// Notes:   Read data answers one cycle after the read request
//
// Behaviour
// - Counter of 16 bits increments on each selected count clock while running.
// - A counter read holds off the count pulse so the value is coherent.
// - Counter is zero after reset and whenever the run bit is clear.
// - Run bit, bit 2 of mode register: 0 stops and clears, 1 counts.
// - Bit 0 of mode register enables the prescaler output.
// - Three channels capture simultaneously from the one counter.
// - A valid edge copies the counter to the channel register and raises its irq.
// - Edge code 00 falling, 01 rising, 11 both; 10 is forbidden.
// - Edge fields sit at bits 3:2, 5:4, 7:6 for channels 0, 1, 2.
// - Bits 1:0 of prescale register select main clock over 4, 8, 32, 128.
// - Inputs sampled at count clock; a level must be seen twice.
// - Bits 1:0 of divider register divide channel 2 captures by 1, 2, 4, 8.
// - A capture during a capture register read still captures and raises irq.
// - First count may lag the start by up to one count clock period.
// - Capture registers are not initialised by reset.
// - Capture registers are read-only, read as whole 16-bit words.
// - Rising or both edge with input high at start raises irq after the third count clock.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_capture_timer (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_b_i,
   input  wire tcc_pkg::tcc_cpu_req_t req_i,
   output logic [15:0]               rdata_o,
   input  wire logic [2:0]           capture_in_i,
   output logic [2:0]                capture_irq_o,
   output logic                      prescaler_out_pin_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [`TCC_PRE_W-1:0] div_mask(input logic [1:0] sel);
      logic [`TCC_PRE_W-1:0] m;
      m = `TCC_DIV4_MASK;
      unique case (sel)
         2'h0: m = `TCC_DIV4_MASK;
         2'h1: m = `TCC_DIV8_MASK;
         2'h2: m = `TCC_DIV32_MASK;
         2'h3: m = `TCC_DIV128_MASK;
      endcase
      return m;
   endfunction

   function automatic logic [2:0] cdiv_mask(input logic [1:0] sel);
      logic [2:0] m;
      m = `TCC_CDIV1_MASK;
      unique case (sel)
         2'h0: m = `TCC_CDIV1_MASK;
         2'h1: m = `TCC_CDIV2_MASK;
         2'h2: m = `TCC_CDIV4_MASK;
         2'h3: m = `TCC_CDIV8_MASK;
      endcase
      return m;
   endfunction

   function automatic logic edge_ok(input logic [1:0] sel, input logic new_lvl);
      logic ok;
      ok = 1'b0;
      unique case (tcc_pkg::tcc_edge_t'(sel))
         tcc_pkg::TCC_EDGE_FALL: ok = !new_lvl;
         tcc_pkg::TCC_EDGE_RISE: ok = new_lvl;
         tcc_pkg::TCC_EDGE_BAD:  ok = 1'b0;
         tcc_pkg::TCC_EDGE_BOTH: ok = 1'b1;
      endcase
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   logic [7:0]  timer_mode_ctl;
   logic [7:0]  prescale_edge_ctl;
   logic [7:0]  capture_divider_ctl;
   logic        run_bit;
   logic        prescaler_out_enable;
   logic [1:0]  count_clk_sel;
   logic [1:0]  capture_div_sel;
   logic [5:0]  edge_sel;
   logic        wr_mode;
   logic        wr_pre;
   logic        wr_cdiv;
   logic        rd_count;

   assign wr_mode  = req_i.wr && req_i.addr == `TCC_ADDR_MODE;
   assign wr_pre   = req_i.wr && req_i.addr == `TCC_ADDR_PRESCALE;
   assign wr_cdiv  = req_i.wr && req_i.addr == `TCC_ADDR_CAPDIV;
   assign rd_count = req_i.rd && req_i.addr == `TCC_ADDR_COUNT;

   // Unused bits are kept at zero whatever is written
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_mode_ctl      <= `TCC_RST_MODE;
         prescale_edge_ctl   <= `TCC_RST_PRESCALE;
         capture_divider_ctl <= `TCC_RST_CAPDIV;
      end else begin
         if (wr_mode) begin
            timer_mode_ctl <= req_i.wdata[7:0] & `TCC_MASK_MODE;
         end
         if (wr_pre) begin
            prescale_edge_ctl <= req_i.wdata[7:0];
         end
         if (wr_cdiv) begin
            capture_divider_ctl <= req_i.wdata[7:0] & `TCC_MASK_CAPDIV;
         end
      end
   end

   assign run_bit              = timer_mode_ctl[`TCC_BIT_RUN];
   assign prescaler_out_enable = timer_mode_ctl[`TCC_BIT_POE];
   assign count_clk_sel        = prescale_edge_ctl[`TCC_FLD_CLK_LO +: 2];
   assign edge_sel             = prescale_edge_ctl[`TCC_FLD_EDGE_LO +: 6];
   assign capture_div_sel      = capture_divider_ctl[`TCC_FLD_CAPDIV_LO +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and count clock

   logic [`TCC_PRE_W-1:0] pre_cnt;
   logic [`TCC_PRE_W-1:0] sel_mask;
   logic                  tick;

   // Free running, so a start falls anywhere in the count period
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_cnt <= '0;
      end else begin
         pre_cnt <= pre_cnt + 1'b1;
      end
   end

   assign sel_mask = div_mask(count_clk_sel);
   assign tick     = (pre_cnt & sel_mask) == sel_mask;

   // Selected clock as a square wave: top bit of the masked field
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prescaler_out_pin_o <= 1'b0;
      end else begin
         prescaler_out_pin_o <= prescaler_out_enable
                                && (pre_cnt & (sel_mask ^ (sel_mask >> 1))) != '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Free-running counter

   logic [15:0] free_run_counter;
   logic        tick_pend;
   logic        count_step;

   // A pulse that lands on a read is deferred one cycle
   assign count_step = (tick || tick_pend) && !rd_count;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_pend <= 1'b0;
      end else begin
         tick_pend <= run_bit && (tick || tick_pend) && rd_count;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         free_run_counter <= `TCC_RST_COUNT;
      end else if (!run_bit) begin
         free_run_counter <= `TCC_RST_COUNT;
      end else if (count_step) begin
         free_run_counter <= free_run_counter + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers, noise filter and edge detection

   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] samp_new;
   logic [2:0] samp_old;
   logic [2:0] filt_lvl;
   logic [2:0] valid_edge;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= capture_in_i;
         sync_b <= sync_a;
      end
   end

   // Filter levels start low while stopped, so a high input at start is a rise
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         samp_new <= '0;
         samp_old <= '0;
         filt_lvl <= '0;
      end else if (!run_bit) begin
         samp_new <= '0;
         samp_old <= '0;
         filt_lvl <= '0;
      end else if (tick) begin
         samp_new <= sync_b;
         samp_old <= samp_new;
         for (int i = 0; i < 3; i++) begin
            if (samp_new[i] == samp_old[i]) begin
               filt_lvl[i] <= samp_new[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         valid_edge[i] = run_bit && tick && samp_new[i] == samp_old[i]
                         && samp_new[i] != filt_lvl[i]
                         && edge_ok(edge_sel[2*i +: 2], samp_new[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel 2 capture divider

   logic [2:0] cdiv_cnt;
   logic [2:0] cdiv_sel_mask;
   logic [2:0] cap_ev;

   assign cdiv_sel_mask = cdiv_mask(capture_div_sel);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cdiv_cnt <= '0;
      end else if (!run_bit) begin
         cdiv_cnt <= '0;
      end else if (valid_edge[2]) begin
         cdiv_cnt <= (cdiv_cnt == cdiv_sel_mask) ? 3'h0 : cdiv_cnt + 3'h1;
      end
   end

   assign cap_ev[1:0] = valid_edge[1:0];
   assign cap_ev[2]   = valid_edge[2] && cdiv_cnt == cdiv_sel_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Capture registers and interrupt requests

   logic [15:0] cap_reg_ch0;
   logic [15:0] cap_reg_ch1;
   logic [15:0] cap_reg_ch2;

   // No reset: contents stay undefined until the first capture
   always_ff @(posedge ref_clk_i) begin
      if (cap_ev[0]) begin
         cap_reg_ch0 <= free_run_counter;
      end
      if (cap_ev[1]) begin
         cap_reg_ch1 <= free_run_counter;
      end
      if (cap_ev[2]) begin
         cap_reg_ch2 <= free_run_counter;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         capture_irq_o <= '0;
      end else begin
         capture_irq_o <= cap_ev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   logic [15:0] next_rdata;

   always_comb begin
      next_rdata = 16'h0000;
      if (req_i.rd) begin
         unique case (req_i.addr)
            `TCC_ADDR_MODE:     next_rdata = {8'h00, timer_mode_ctl};
            `TCC_ADDR_PRESCALE: next_rdata = {8'h00, prescale_edge_ctl};
            `TCC_ADDR_CAPDIV:   next_rdata = {8'h00, capture_divider_ctl};
            `TCC_ADDR_COUNT:    next_rdata = free_run_counter;
            `TCC_ADDR_CAP0:     next_rdata = cap_reg_ch0;
            `TCC_ADDR_CAP1:     next_rdata = cap_reg_ch1;
            `TCC_ADDR_CAP2:     next_rdata = cap_reg_ch2;
            default:            next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_stop_clears: assert property (!run_bit |=> free_run_counter == 16'h0000)
      else $error("counter not zero while stopped");

   chk_count_step: assert property (
      run_bit && tick && !rd_count && !tick_pend && $past(run_bit)
      |=> free_run_counter == $past(free_run_counter) + 16'h0001)
      else $error("counter did not step on count pulse");

   chk_read_hold: assert property (run_bit && rd_count ##1 run_bit
      |-> free_run_counter == $past(free_run_counter))
      else $error("counter moved during read");

   chk_read_defer: assert property (run_bit && rd_count && tick ##1 run_bit && !rd_count
      ##1 run_bit |-> free_run_counter == $past(free_run_counter, 2) + 16'h0001)
      else $error("held count pulse was lost");

   chk_tick_space: assert property (tick |=> !tick [*3])
      else $error("count pulse faster than main clock over four");

   chk_capture_val: assert property (cap_ev[0] |=> cap_reg_ch0 == $past(free_run_counter)
      && capture_irq_o[0])
      else $error("channel 0 capture value or irq wrong");

   chk_edge_fall: assert property (valid_edge[1] && edge_sel[3:2] == 2'h0
      |-> !samp_new[1] && filt_lvl[1])
      else $error("falling selection accepted another edge");

   chk_two_samples: assert property ($changed(filt_lvl[0]) && run_bit && $past(run_bit)
      |-> filt_lvl[0] == $past(samp_new[0]) && filt_lvl[0] == $past(samp_old[0]))
      else $error("filtered level moved without two matching samples");

   chk_div_one: assert property (valid_edge[2] && capture_div_sel == 2'h0
      |=> capture_irq_o[2])
      else $error("undivided channel 2 edge missed");

   chk_pin_gate: assert property (!prescaler_out_enable |=> !prescaler_out_pin_o)
      else $error("prescaler pin driven while disabled");

   cov_three_caps: cover property (cap_ev == 3'h7);
   cov_div8_cap:   cover property (cap_ev[2] && capture_div_sel == 2'h3);
   cov_read_clash: cover property (cap_ev[0] && req_i.rd && req_i.addr == `TCC_ADDR_CAP0);
   cov_read_hold:  cover property (run_bit && rd_count && tick);

endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench of the three-channel capture timer
// Assumes: Requests driven at the falling edge, one-cycle strobes
// Notes:   Capture pulses come from the pulse source model
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
   logic                  ref_clk;
   logic                  rst_b;
   tcc_pkg::tcc_cpu_req_t req;
   logic [15:0]           rdata;
   logic [2:0]            cap_in;
   logic [2:0]            irq;
   logic                  prescaler_out_pin;
   int                    n_mismatch;
   int                    n_checks;
   int                    irq_cnt [3];
   int                    s [3];
   logic [15:0]           v;
   logic [15:0]           c;
   int                    hi;
   int                    k;

   tcc_capture_timer dut (
      .ref_clk_i           (ref_clk),
      .rst_b_i             (rst_b),
      .req_i               (req),
      .rdata_o             (rdata),
      .capture_in_i        (cap_in),
      .capture_irq_o       (irq),
      .prescaler_out_pin_o (prescaler_out_pin)
   );

   tcc_pulse_src src (
      .ref_clk_i (ref_clk),
      .pins_o    (cap_in)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (rst_b === 1'b1) begin
         for (int i = 0; i < 3; i++) irq_cnt[i] += (irq[i] === 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: {8'h00, d}};
      @(negedge ref_clk);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      // Read data stands only in the cycle after the strobe edge
      @(negedge ref_clk);
      d = rdata;
      req.rd = 1'b0;
   endtask

   // Stop, configure, then restart the timer
   task automatic cfg(input logic [7:0] pre, input logic [7:0] div);
      wr(`TCC_ADDR_MODE, 8'h00);
      wr(`TCC_ADDR_PRESCALE, pre);
      wr(`TCC_ADDR_CAPDIV, div);
      wr(`TCC_ADDR_MODE, 8'h04);
   endtask

   task automatic snap();
      for (int i = 0; i < 3; i++) s[i] = irq_cnt[i];
   endtask

   task automatic chk_irq(input int e0, input int e1, input int e2);
      `CHK("irq_ch0", e0, irq_cnt[0] - s[0])
      `CHK("irq_ch1", e1, irq_cnt[1] - s[1])
      `CHK("irq_ch2", e2, irq_cnt[2] - s[2])
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      logic [7:0] pre [3];
      n_mismatch = 0;
      n_checks = 0;
      irq_cnt = '{0, 0, 0};
      req = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
      rst_b = 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      // Reset values, unmapped read, masked unused bits
      rd(`TCC_ADDR_MODE, v);     `CHK("mode_rst", 16'h0000, v)
      rd(`TCC_ADDR_PRESCALE, v); `CHK("pre_rst", 16'h0000, v)
      rd(`TCC_ADDR_CAPDIV, v);   `CHK("div_rst", 16'h0000, v)
      rd(`TCC_ADDR_COUNT, v);    `CHK("cnt_rst", 16'h0000, v)
      rd(16'hff20, v);           `CHK("unmapped", 16'h0000, v)
      wr(`TCC_ADDR_MODE, 8'hfa);
      rd(`TCC_ADDR_MODE, v);     `CHK("mode_mask", 16'h0000, v)
      wr(`TCC_ADDR_CAPDIV, 8'h03);
      rd(`TCC_ADDR_CAPDIV, v);   `CHK("div_rw", 16'h0003, v)
      // Prescaler pin: quiet when disabled, 50 percent duty when enabled
      for (int e = 0; e < 2; e++) begin
         wr(`TCC_ADDR_MODE, e[7:0]);
         hi = 0;
         repeat (64) begin
            @(negedge ref_clk);
            hi += (prescaler_out_pin === 1'b1);
         end
         `CHK("tpo_high", e * 32, hi)
      end
      // Count rate for every clock selection, clear on stop
      for (int sel = 0; sel < 4; sel++) begin
         cfg(sel[7:0], 8'h00);
         rd(`TCC_ADDR_COUNT, c);
         repeat (512) @(negedge ref_clk);
         rd(`TCC_ADDR_COUNT, v);
         k = 512 / (sel == 0 ? 4 : sel == 1 ? 8 : sel == 2 ? 32 : 128);
         hi = int'(v - c) - k;
         `CHK("cnt_rate", 1'b1, hi >= -1 && hi <= 1)
         wr(`TCC_ADDR_MODE, 8'h00);
         rd(`TCC_ADDR_COUNT, v);  `CHK("cnt_clr", 16'h0000, v)
      end
      // Edge codes rotated over the three channels
      pre = '{8'hc4, 8'h1c, 8'h70};
      for (int r = 0; r < 3; r++) begin
         cfg(pre[r], 8'h00);
         snap();
         src.drive(3'h7);
         repeat (40) @(negedge ref_clk);
         chk_irq(pre[r][3:2] != 2'h0, pre[r][5:4] != 2'h0, pre[r][7:6] != 2'h0);
         snap();
         src.drive(3'h0);
         repeat (40) @(negedge ref_clk);
         chk_irq(pre[r][3:2] != 2'h1, pre[r][5:4] != 2'h1, pre[r][7:6] != 2'h1);
         for (int ch = 0; ch < 3; ch++) begin
            rd(`TCC_ADDR_CAP0 + 16'(2 * ch), c);
            rd(`TCC_ADDR_COUNT, v);
            `CHK("cap_value", 1'b1, c <= v && v - c < 16'd30)
         end
      end
      // Capture registers ignore writes
      rd(`TCC_ADDR_CAP0, c);
      wr(`TCC_ADDR_CAP0, 8'h5a);
      rd(`TCC_ADDR_CAP0, v);     `CHK("cap_ro", c, v)
      // Glitch of three clocks is filtered out
      cfg(8'hc4, 8'h00);
      snap();
      src.pulse(3'h7, 3);
      repeat (40) @(negedge ref_clk);
      chk_irq(0, 0, 0);
      // High input at start raises rising and both channels
      wr(`TCC_ADDR_MODE, 8'h00);
      src.drive(3'h7);
      repeat (8) @(negedge ref_clk);
      snap();
      wr(`TCC_ADDR_MODE, 8'h04);
      repeat (40) @(negedge ref_clk);
      chk_irq(1, 0, 1);
      src.drive(3'h0);
      // Channel 2 pulse divider, every code
      for (int d = 0; d < 4; d++) begin
         cfg(8'h40, d[7:0]);
         repeat (20) @(negedge ref_clk);
         snap();
         repeat (8) begin
            src.pulse(3'h4, 20);
            repeat (20) @(negedge ref_clk);
         end
         `CHK("div_ch2", 8 >> d, irq_cnt[2] - s[2])
      end
      final_report();
   end
endmodule

`default_nettype wire

// *** testbench/tcc_pulse_src.sv ***
// Purpose: External pulse source on the three capture input pins
// Assumes: Pins change just after the falling edge of the main clock
// Notes:   Levels are held until the bench asks for a new one
`timescale 1ns/1ps
`default_nettype none

module tcc_pulse_src (
   input  wire logic       ref_clk_i,
   output var  logic [2:0] pins_o
);
   initial pins_o = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   task automatic drive(input logic [2:0] lvl);
      @(negedge ref_clk_i);
      pins_o = lvl;
   endtask

   // Flip the masked pins for width cycles, then restore them
   task automatic pulse(input logic [2:0] mask, input int width);
      logic [2:0] old;
      old = pins_o;
      drive(old ^ mask);
      repeat (width) @(negedge ref_clk_i);
      pins_o = old;
   endtask
endmodule

`default_nettype wire
